// *** rtl/serial_prom_regs.vh ***
/*
 Constants for the serial PROM programming-mode block: array geometry,
 supply level codes, the polarity word and timing counts.
 Assumes sys_clk at 20 MHz.
*/
`ifndef SERIAL_PROM_REGS_VH
`define SERIAL_PROM_REGS_VH

// ============================================================
// Array geometry
`define WORD_BITS 8
`define BIT_IDX_W 3
`define ADDR_W 8
`define LAST_ADDR 8'hFF
`define POL_ADDR 9'h100
`define POL_LOW_WORD 8'h00
`define POL_HIGH_WORD 8'hFF
`define POL_RESET 1'b1

// ============================================================
// Supply level codes on supplyLevel[1:0]
`define SUP_NORMAL 2'h0
`define SUP_ENTRY 2'h1
`define SUP_HIGH 2'h2

// ============================================================
// Timing: programming strobe, 0.95 ms minimum
`define CLK_HZ 20000000
`define PGM_MIN_US 950
`define PGM_MIN_CYC ((`PGM_MIN_US * (`CLK_HZ / 1000000)))

`endif

// *** rtl/pin_sync.v ***
/*
 Two-flop synchroniser for a bundle of pin inputs.
 Assumes the inputs are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module pin_sync #(
    parameter W = 6
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [W-1:0] pinIn,
    output reg [W-1:0] pinOut
);
    reg [W-1:0] stage1_r;

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            stage1_r <= {W{1'b0}};
            pinOut <= {W{1'b0}};
        end else begin
            stage1_r <= pinIn;
            pinOut <= stage1_r;
        end
    end
endmodule // pin_sync

// *** rtl/serial_prom_program_mode.v ***
/*
 Programming-mode logic of a one-bit serial configuration PROM.
 The programmer's clock, chip select, output gate, data and supply level
 arrive as pins and are synchronised to sys_clk; the PROM clock is
 sampled, so it must stay well below the system clock rate.
 The programmer holds each clock phase for at least three sys_clk cycles;
 array contents are not cleared by reset.
*/
`timescale 1ns/1ps
`include "serial_prom_regs.vh"
module serial_prom_program_mode #(
    parameter PGM_MIN_CYCLES = `PGM_MIN_CYC
) (
    input wire sys_clk,
    input wire rst_n,
    input wire promClk,
    input wire chipSelect,
    input wire outputGate,
    input wire dataIn,
    input wire [1:0] supplyLevel,
    output reg dataOut,
    output reg dataOe,
    output reg cascade_select_out,
    output reg programMode
);
    localparam ST_IDLE = 2'd0;
    localparam ST_HIGH1 = 2'd1;
    localparam ST_HIGH2 = 2'd2;
    localparam ST_PROG = 2'd3;

    wire [5:0] syncPins;
    wire clkS;
    wire csS;
    wire ogS;
    wire dinS;
    wire [1:0] supS;
    reg clkPrev_r;
    reg [1:0] syncWarm_r;
    reg [1:0] state_r;
    reg [1:0] stateNxt;
    reg [`ADDR_W-1:0] addr_r;
    reg overflow_r;
    reg [`BIT_IDX_W-1:0] bitIdx_r;
    reg [`WORD_BITS-1:0] shiftIn_r;
    reg [`WORD_BITS-1:0] mem [0:(1<<`ADDR_W)-1];
    reg [`WORD_BITS-1:0] polWord_r;
    reg endSeen_r;
    reg strobeOn_r;
    reg [15:0] strobeCnt_r;
    reg [`WORD_BITS-1:0] rdWord;

    // ============================================================
    // Pin synchronisation and clock edge detection
    pin_sync #(.W(6)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pinIn({promClk, chipSelect, outputGate, dataIn, supplyLevel}),
        .pinOut(syncPins)
    );
    assign clkS = syncPins[5];
    assign csS = syncPins[4];
    assign ogS = syncPins[3];
    assign dinS = syncPins[2];
    assign supS = syncPins[1:0];

    // Masked until the sync pipe holds real pin levels, so an idle-High clock gives no false rise
    wire clkRise = clkS & ~clkPrev_r & (syncWarm_r == 2'h3);

    function polFromWord;
        input [`WORD_BITS-1:0] w;
        begin
            polFromWord = (w == `POL_LOW_WORD) ? 1'b0 : `POL_RESET;
        end
    endfunction

    function [`BIT_IDX_W-1:0] nextBitIdx;
        input [`BIT_IDX_W-1:0] idx;
        begin
            nextBitIdx = (idx == `WORD_BITS - 1) ? {`BIT_IDX_W{1'b0}} : idx + 1'b1;
        end
    endfunction

    // ============================================================
    // Entry sequence and exit
    always @* begin
        stateNxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (clkRise && csS && ogS && supS == `SUP_HIGH) begin
                    stateNxt = ST_HIGH1;
                end
            end
            ST_HIGH1: begin
                if (clkRise) begin
                    if (csS && ogS && supS == `SUP_HIGH) begin
                        stateNxt = ST_HIGH2;
                    end else begin
                        stateNxt = ST_IDLE;
                    end
                end
            end
            ST_HIGH2: begin
                if (clkRise) begin
                    if (csS && ogS && supS == `SUP_ENTRY) begin
                        stateNxt = ST_PROG;
                    end else if (!(csS && ogS && supS == `SUP_HIGH)) begin
                        stateNxt = ST_IDLE;
                    end
                end
            end
            ST_PROG: begin
                if (!csS && !ogS) begin
                    stateNxt = ST_IDLE;
                end
            end
            default: stateNxt = ST_IDLE;
        endcase
    end

    wire inProg = (state_r == ST_PROG);
    // Fixed gate meaning in programming mode, stored polarity ignored
    wire doLoad = inProg && clkRise && csS && ogS;
    wire doRead = inProg && clkRise && !csS && ogS;
    wire doAdv = inProg && clkRise && csS && !ogS;
    wire lastBit = (bitIdx_r == `WORD_BITS - 1);

    // ============================================================
    // Word under the read pointer
    always @* begin
        rdWord = overflow_r ? polWord_r : mem[addr_r];
    end

    // ============================================================
    // Counters, shifting and programming strobe
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            clkPrev_r <= 1'b0;
            syncWarm_r <= 2'h0;
            addr_r <= {`ADDR_W{1'b0}};
            overflow_r <= 1'b0;
            bitIdx_r <= {`BIT_IDX_W{1'b0}};
            shiftIn_r <= {`WORD_BITS{1'b0}};
            polWord_r <= `POL_HIGH_WORD;
            endSeen_r <= 1'b0;
            strobeOn_r <= 1'b0;
            strobeCnt_r <= 16'h0000;
            dataOut <= 1'b0;
            dataOe <= 1'b0;
            cascade_select_out <= 1'b1;
            programMode <= 1'b0;
        end else begin
            clkPrev_r <= clkS;
            if (syncWarm_r != 2'h3) begin
                syncWarm_r <= syncWarm_r + 2'h1;
            end
            state_r <= stateNxt;
            programMode <= (stateNxt == ST_PROG);
            dataOe <= inProg && !csS && ogS;
            if (!inProg) begin
                bitIdx_r <= {`BIT_IDX_W{1'b0}};
                endSeen_r <= 1'b0;
                if (stateNxt == ST_PROG) begin
                    addr_r <= {`ADDR_W{1'b0}};
                    overflow_r <= 1'b0;
                end
            end
            if (doLoad) begin
                shiftIn_r <= {shiftIn_r[`WORD_BITS-2:0], dinS};
                bitIdx_r <= nextBitIdx(bitIdx_r);
            end
            if (doRead) begin
                dataOut <= rdWord[`WORD_BITS-1-bitIdx_r];
                bitIdx_r <= nextBitIdx(bitIdx_r);
                if (lastBit && (overflow_r || addr_r == `LAST_ADDR)) begin
                    endSeen_r <= 1'b1;
                end
            end
            if (doAdv) begin
                bitIdx_r <= {`BIT_IDX_W{1'b0}};
                if (addr_r == `LAST_ADDR) begin
                    overflow_r <= 1'b1;
                end
                if (!overflow_r) begin
                    addr_r <= addr_r + 1'b1;
                end
            end
            // Supply strobe at the high level writes the loaded word
            if (inProg && csS && supS == `SUP_HIGH) begin
                strobeOn_r <= 1'b1;
                if (strobeCnt_r != 16'hFFFF) begin
                    strobeCnt_r <= strobeCnt_r + 16'h0001;
                end
            end else begin
                strobeOn_r <= 1'b0;
                strobeCnt_r <= 16'h0000;
                if (strobeOn_r && strobeCnt_r >= PGM_MIN_CYCLES[15:0]) begin
                    if (overflow_r) begin
                        polWord_r <= shiftIn_r;
                    end else begin
                        mem[addr_r] <= shiftIn_r;
                    end
                end
            end
            // Cascade output: polarity sense, then end-of-array marker
            if (inProg && endSeen_r) begin
                cascade_select_out <= 1'b0;
            end else begin
                cascade_select_out <= polFromWord(polWord_r);
            end
        end
    end
endmodule // serial_prom_program_mode

// *** verification/serial_prom_program_mode_sva.sv ***
/* Checker on the ports of serial_prom_program_mode.
   Assumes pins pass two sync flops; a clock rise acts on the third edge. */
`timescale 1ns/1ps
`include "serial_prom_regs.vh"
module serial_prom_program_mode_sva (
    input wire sys_clk,
    input wire rst_n,
    input wire promClk,
    input wire chipSelect,
    input wire outputGate,
    input wire dataIn,
    input wire [1:0] supplyLevel,
    input wire dataOut,
    input wire dataOe,
    input wire cascade_select_out,
    input wire programMode
);
    // ========
    // Pin images as the block sees them: {clk, select, gate, supply}
    reg [4:0] pA_r, pB_r, pC_r;
    always @(posedge sys_clk) begin
        pA_r <= rst_n ? {promClk, chipSelect, outputGate, supplyLevel} : 5'h00;
        pB_r <= rst_n ? pA_r : 5'h00;
        pC_r <= rst_n ? pB_r : 5'h00;
    end
    wire rise = pB_r[4] & ~pC_r[4];
    wire rdEdge = programMode & rise & ~pB_r[3] & pB_r[2];
    wire entEdge = rise & pB_r[3] & pB_r[2] & (pB_r[1:0] == `SUP_ENTRY);
    wire quit = ~pB_r[3] & ~pB_r[2];
    sequence sRead;
        rdEdge;
    endsequence
    sequence sQuit;
        programMode && quit;
    endsequence
    // ========
    // Properties
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_reset_values: assert property (disable iff (1'h0) !rst_n |=> !programMode && !dataOe && cascade_select_out)
        else $error("reset values wrong");
    a_read_drives: assert property (sRead |=> dataOe)
        else $error("read edge did not drive");
    a_exit_on_low: assert property (sQuit |=> !programMode)
        else $error("mode kept with select and gate low");
    a_mode_holds: assert property (programMode && !quit |=> programMode)
        else $error("mode left early");
    a_entry_level: assert property ($rose(programMode) |-> $past(entEdge))
        else $error("mode entered without entry edge");
    a_bit_per_edge: assert property (programMode && !rdEdge && !quit |=> $stable(dataOut))
        else $error("data moved without read edge");
    a_oe_from_read: assert property ($rose(dataOe) |-> $past(programMode && ~pB_r[3] && pB_r[2]))
        else $error("driver on without read edge");
    a_idle_no_drive: assert property (!programMode |=> !$rose(dataOe))
        else $error("driver on outside mode");
endmodule // serial_prom_program_mode_sva
bind serial_prom_program_mode serial_prom_program_mode_sva serial_prom_program_mode_sva_inst (.sys_clk(sys_clk),
    .rst_n(rst_n), .promClk(promClk), .chipSelect(chipSelect), .outputGate(outputGate), .dataIn(dataIn),
    .supplyLevel(supplyLevel), .dataOut(dataOut), .dataOe(dataOe), .cascade_select_out(cascade_select_out),
    .programMode(programMode));

// *** verification/prom_programmer.sv ***
/* Programmer model driving clock, select, gate, data and supply.
   Assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ps
module prom_programmer (
    input wire sys_clk,
    input wire dataOut,
    input wire dataOe,
    output reg promClk,
    output reg chipSelect,
    output reg outputGate,
    output wire dataLine,
    output reg [1:0] supplyLevel
);
    reg d = 1'h0;
    initial {promClk, chipSelect, outputGate, supplyLevel} = 5'h10;
    // Released line shows the model's bit d, inverted while select is low and gate High
    assign dataLine = dataOe ? dataOut : ((chipSelect | ~outputGate) ? d : ~d);
    // ========
    // One clock rise; controls {select, gate, bit, supply} change after 250 ns of High
    task step(input [4:0] v);
        begin
            @(posedge sys_clk) #1 {chipSelect, outputGate, d, supplyLevel} = v;
            @(posedge sys_clk) #1 promClk = 1'h0;
            repeat (4) @(posedge sys_clk);
            #1 promClk = 1'h1;
            repeat (4) @(posedge sys_clk);
            #1;
        end
    endtask
    task enter;
        begin
            step(5'h1A);
            step(5'h1A);
            step(5'h19);
        end
    endtask
    // Strobe of 21 cycles, above the 20-cycle minimum of the shortened part
    task strobe;
        begin
            supplyLevel = 2'h2;
            repeat (21) @(posedge sys_clk);
            #1 supplyLevel = 2'h1;
        end
    endtask
endmodule // prom_programmer

// *** verification/serial_prom_program_mode_tb.sv ***
/* Self-checking bench for serial_prom_program_mode.
   Assumes the programming strobe minimum shortened to 20 cycles. */
`timescale 1ns/1ps
module serial_prom_program_mode_tb;
    reg sysClk = 1'h0;
    reg rstN = 1'h0;
    wire pClk, cSel, oGate, dLine, dOut, dOe, cOut, pMode;
    wire [1:0] sup;
    integer fail_count = 0;
    integer tests_run = 0;
    integer i, k;
    reg [7:0] mem [0:3];
    reg [7:0] rd;
    reg [31:0] rv;
    always #25 sysClk = ~sysClk;
    prom_programmer prom_programmer_inst (.sys_clk(sysClk), .dataOut(dOut), .dataOe(dOe), .promClk(pClk),
        .chipSelect(cSel), .outputGate(oGate), .dataLine(dLine), .supplyLevel(sup));
    serial_prom_program_mode #(.PGM_MIN_CYCLES(20)) serial_prom_program_mode_inst (.sys_clk(sysClk),
        .rst_n(rstN), .promClk(pClk), .chipSelect(cSel), .outputGate(oGate), .dataIn(dLine),
        .supplyLevel(sup), .dataOut(dOut), .dataOe(dOe), .cascade_select_out(cOut), .programMode(pMode));
    function [7:0] polBit(input [7:0] w);
        polBit = {7'h00, |w};
    endfunction
    // ========
    // Checks and word transfers
    task check(input [31:0] nm, input [7:0] seen, input [7:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task loadw(input [7:0] w);
        for (k = 7; k >= 0; k = k - 1) prom_programmer_inst.step({2'h3, w[k], 2'h1});
    endtask
    task readw;
        for (k = 7; k >= 0; k = k - 1) begin
            prom_programmer_inst.step(5'h09);
            rd[k] = dOut;
        end
    endtask
    task report_and_stop;
        begin
            if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        repeat (20000) @(posedge sysClk);
        fail_count = fail_count + 1;
        report_and_stop;
    end
    initial begin
        mem[0] = 8'h80;
        rd = $urandom(32'hF746);
        for (i = 1; i < 4; i = i + 1) mem[i] = $urandom;
        repeat (6) @(posedge sysClk);
        #1 rstN = 1'h1;
        @(posedge sysClk) #1;
        check("mode", pMode, 8'h00);
        check("casc", cOut, polBit(8'hFF));
        for (i = 0; i < 6; i = i + 1) begin
            rv = $urandom;
            prom_programmer_inst.step({rv[4:2], 1'h0, rv[0]});
            check("mode", pMode, 8'h00);
            check("oe", dOe, 8'h00);
        end
        prom_programmer_inst.enter;
        check("mode", pMode, 8'h01);
        for (i = 0; i < 4; i = i + 1) begin
            loadw(mem[i]);
            prom_programmer_inst.strobe;
            readw;
            check("data", rd, mem[i]);
            check("oe", dOe, 8'h01);
            check("casc", cOut, 8'h01);
            prom_programmer_inst.step(5'h11);
        end
        prom_programmer_inst.step(5'h00);
        check("mode", pMode, 8'h00);
        prom_programmer_inst.enter;
        readw;
        check("data", rd, mem[0]);
        for (i = 0; i < 255; i = i + 1) prom_programmer_inst.step(5'h11);
        readw;
        check("casc", cOut, 8'h00);
        prom_programmer_inst.step(5'h11);
        loadw(8'h00);
        prom_programmer_inst.strobe;
        prom_programmer_inst.step(5'h00);
        prom_programmer_inst.enter;
        check("casc", cOut, polBit(8'h00));
        readw;
        check("data", rd, mem[0]);
        report_and_stop;
    end
endmodule // serial_prom_program_mode_tb
